/* src/cfsg_pkg.sv */
// Shared constants for the clock fanout block with synchronous output gate.
// Assumes every user samples the input clocks as data on the one system clock.
package cfsg_pkg;
  localparam int unsigned FANOUT_WIDTH = 4;
  localparam logic        GATE_RST     = 1'h0;
  localparam logic        LEVEL_RST    = 1'h0;
  localparam logic        TRUE_RST     = 1'h0;
  localparam logic        COMPL_RST    = 1'h1;
  localparam logic        SEL_SYSTEM   = 1'h0;
  localparam logic        SEL_SCAN     = 1'h1;
endpackage

/* src/cfsg_input_select.sv */
// Differential receiver and two-way clock multiplexer feeding the fanout core.
// Assumes all inputs are levels sampled on the system clock by the caller.
`timescale 1ns/1ns
module cfsg_input_select (
  input  wire logic sys_clk_in,
  input  wire logic sys_clk_in_n,
  input  wire logic scan_clk_in,
  input  wire logic clk_sel,
  output logic      sel_level
);
  logic sys_level;

  // An open pair sits with both legs low and must read as a low clock
  assign sys_level = sys_clk_in & ~sys_clk_in_n;

  always_comb begin
    case (clk_sel)
      cfsg_pkg::SEL_SCAN: sel_level = scan_clk_in;
      // Undriven or unknown select falls here, acting as the pull-down
      default:            sel_level = sys_level;
    endcase
  end
endmodule

/* src/cfsg_fanout_gate.sv */
// Top of the clock fanout block: input select, falling-edge enable capture,
// glitch-free gate and four differential output pairs.
// Assumes input clocks are far slower than the 20 MHz system clock and are
// sampled as data; sys_rst only gives the model a defined start.
`timescale 1ns/1ns
// Overview of operation
// - Select low routes the differential system clock to every output.
// - Select high routes the single-ended scan clock to the outputs.
// - An unconnected select reads as low, choosing the system clock.
// - The chosen clock drives four identical differential output pairs.
// - Gated state only changes while the selected input level is already low.
// - Active-low enable is captured on the selected clock's falling edge.
// - Enable high forces true outputs low from the next falling edge on.
module cfsg_fanout_gate #(
  parameter int unsigned NUM_OUT = cfsg_pkg::FANOUT_WIDTH
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               sys_clk_in,
  input  wire logic               sys_clk_in_n,
  input  wire logic               scan_clk_in,
  input  wire logic               clk_sel,
  input  wire logic               enable_n,
  output logic [NUM_OUT-1:0]      fanout_clock_outputs,
  output logic [NUM_OUT-1:0]      fanout_clock_outputs_n
);
  typedef struct packed {
    logic               prev_level;
    logic               gate_open;
    logic [NUM_OUT-1:0] q;
    logic [NUM_OUT-1:0] qn;
  } cfsg_state_t;

  cfsg_state_t st_ff;
  cfsg_state_t nxt_st;
  logic        sel_level;
  logic        fall_edge;

  // Differential receiver decode for the checks below; an open pair reads low
  function automatic logic cfsg_rx_level(
    input logic pos,
    input logic neg
  );
    return pos & ~neg;
  endfunction

  cfsg_input_select u_select (
    .sys_clk_in   (sys_clk_in),
    .sys_clk_in_n (sys_clk_in_n),
    .scan_clk_in  (scan_clk_in),
    .clk_sel      (clk_sel),
    .sel_level    (sel_level)
  );

  assign fall_edge = st_ff.prev_level & ~sel_level;

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.prev_level = sel_level;
    // Capturing only on a falling edge means the level is low right then,
    // so a gate change can never cut a high phase short
    if (fall_edge) begin
      nxt_st.gate_open = ~enable_n;
    end
    for (int i = 0; i < NUM_OUT; i++) begin
      nxt_st.q[i]  = sel_level & nxt_st.gate_open;
      nxt_st.qn[i] = ~nxt_st.q[i];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff.prev_level <= cfsg_pkg::LEVEL_RST;
      st_ff.gate_open  <= cfsg_pkg::GATE_RST;
      st_ff.q          <= {NUM_OUT{cfsg_pkg::TRUE_RST}};
      st_ff.qn         <= {NUM_OUT{cfsg_pkg::COMPL_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fanout_clock_outputs   = st_ff.q;
  assign fanout_clock_outputs_n = st_ff.qn;

  AST_SYS_ROUTE: assert property (
    @(posedge clock) disable iff (sys_rst)
    (clk_sel == cfsg_pkg::SEL_SYSTEM && st_ff.gate_open && !fall_edge)
      |=> fanout_clock_outputs[0] == $past(cfsg_rx_level(sys_clk_in, sys_clk_in_n)))
    else $error("system clock not routed while selected");

  AST_SCAN_ROUTE: assert property (
    @(posedge clock) disable iff (sys_rst)
    (clk_sel == cfsg_pkg::SEL_SCAN && st_ff.gate_open && !fall_edge)
      |=> fanout_clock_outputs[0] == $past(scan_clk_in))
    else $error("scan clock not routed while selected");

  AST_DEFAULT_SYS: assert property (
    @(posedge clock) disable iff (sys_rst)
    // Case inequality so a floating select is checked, not skipped
    (clk_sel !== cfsg_pkg::SEL_SCAN) |-> sel_level == cfsg_rx_level(sys_clk_in, sys_clk_in_n))
    else $error("select not high but system clock not chosen");

  AST_FANOUT_SAME: assert property (
    @(posedge clock) disable iff (sys_rst)
    fanout_clock_outputs == {NUM_OUT{fanout_clock_outputs[0]}})
    else $error("output pairs differ");

  AST_CHANGE_LOW: assert property (
    @(posedge clock) disable iff (sys_rst)
    !$stable(st_ff.gate_open) |-> fanout_clock_outputs == '0 && !$past(sel_level))
    else $error("gate changed while outputs high");

  AST_CAPTURE_FALL: assert property (
    @(posedge clock) disable iff (sys_rst)
    fall_edge |=> st_ff.gate_open == !$past(enable_n))
    else $error("enable not captured on falling edge");

  AST_HOLD_NO_FALL: assert property (
    @(posedge clock) disable iff (sys_rst)
    !fall_edge |=> $stable(st_ff.gate_open))
    else $error("gate moved without a falling edge");

  AST_DISABLE_LOW: assert property (
    @(posedge clock) disable iff (sys_rst)
    (fall_edge && enable_n) |=> (fanout_clock_outputs == '0) ##1 (!st_ff.gate_open || $past(!enable_n)))
    else $error("outputs not forced low after disable");

  AST_GATED_LOW: assert property (
    @(posedge clock) disable iff (sys_rst)
    !st_ff.gate_open |-> fanout_clock_outputs == '0)
    else $error("output high while gated");

  AST_COMPLEMENT: assert property (
    @(posedge clock) disable iff (sys_rst)
    fanout_clock_outputs_n == ~fanout_clock_outputs)
    else $error("complement output mismatch");

  // A falling output always follows a low input level, never a gate change
  AST_NO_RUNT_FALL: assert property (
    @(posedge clock) disable iff (sys_rst)
    $fell(fanout_clock_outputs[0])
      |-> !$past(sel_level))
    else $error("output fell while the input level was high");

  AST_NO_RUNT_RISE: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(fanout_clock_outputs[0])
      |-> $past(st_ff.gate_open))
    else $error("output rose on the cycle the gate opened");

  AST_FALL_OUT_LOW: assert property (
    @(posedge clock) disable iff (sys_rst)
    fall_edge
      |=> fanout_clock_outputs == '0 && fanout_clock_outputs_n == '1)
    else $error("outputs not low after a falling edge");

  AST_GATE_HOLD_OFF: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!st_ff.gate_open && enable_n)
      |=> !st_ff.gate_open)
    else $error("gate opened while enable was high");

  AST_GATE_HOLD_ON: assert property (
    @(posedge clock) disable iff (sys_rst)
    (st_ff.gate_open && !enable_n)
      |=> st_ff.gate_open)
    else $error("gate closed while enable was low");

  AST_ENABLE_FROM_FALL: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(st_ff.gate_open)
      |-> $past(fall_edge) && !$past(enable_n))
    else $error("gate opened without a falling edge and low enable");

  // Reset is a modelling aid only; it parks the pairs as a closed gate would
  AST_RESET_STATE: assert property (
    @(posedge clock)
    sys_rst
      |=> fanout_clock_outputs == '0 && fanout_clock_outputs_n == '1 && !st_ff.gate_open)
    else $error("outputs not parked after reset");

  AST_PREV_TRACK: assert property (
    @(posedge clock) disable iff (sys_rst)
    1'h1
      |=> st_ff.prev_level == $past(sel_level))
    else $error("edge detector lost the previous level");

  AST_SEL_SCAN_MUX: assert property (
    @(posedge clock) disable iff (sys_rst)
    (clk_sel == cfsg_pkg::SEL_SCAN)
      |-> sel_level == scan_clk_in)
    else $error("scan select did not pass the scan clock");

  AST_SEL_SYS_MUX: assert property (
    @(posedge clock) disable iff (sys_rst)
    (clk_sel == cfsg_pkg::SEL_SYSTEM)
      |-> sel_level == cfsg_rx_level(sys_clk_in, sys_clk_in_n))
    else $error("system select did not pass the system clock");

  AST_OPEN_PAIR_LOW: assert property (
    @(posedge clock) disable iff (sys_rst)
    (clk_sel !== cfsg_pkg::SEL_SCAN && !sys_clk_in && !sys_clk_in_n)
      |=> fanout_clock_outputs == '0)
    else $error("open input pair did not read low");

  // Per-pair checks, so a stuck leg shows up with its own index
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_pair_chk
    AST_PAIR_COMPL: assert property (
      @(posedge clock) disable iff (sys_rst)
      fanout_clock_outputs_n[g] == ~fanout_clock_outputs[g])
      else $error("pair complement mismatch");

    AST_PAIR_MATCH: assert property (
      @(posedge clock) disable iff (sys_rst)
      fanout_clock_outputs[g] == fanout_clock_outputs[0])
      else $error("pair differs from pair zero");

    AST_PAIR_GATED: assert property (
      @(posedge clock) disable iff (sys_rst)
      !st_ff.gate_open
        |-> !fanout_clock_outputs[g] && fanout_clock_outputs_n[g])
      else $error("pair not parked low while gated");
  end
endmodule

/* verification/cfsg_clk_src.sv */
// Clock source model: differential system clock and slower scan clock.
// Assumes the 20 MHz bench clock; both clocks step on its falling edge.
`timescale 1ns/1ns
module cfsg_clk_src #(
  parameter int SYS_HALF  = 3,
  parameter int SCAN_HALF = 5
) (
  input  wire logic clock,
  output logic      sys_clk_in,
  output logic      sys_clk_in_n,
  output logic      scan_clk_in
);
  int sys_cnt  = 0;
  int scan_cnt = 0;
  initial sys_clk_in = 1'h0;
  initial scan_clk_in = 1'h0;
  // Both legs always driven, so the receiver never sees an open input
  assign sys_clk_in_n = ~sys_clk_in;
  always @(negedge clock) begin
    sys_cnt <= (sys_cnt == SYS_HALF - 1) ? 0 : sys_cnt + 1;
    scan_cnt <= (scan_cnt == SCAN_HALF - 1) ? 0 : scan_cnt + 1;
    if (sys_cnt == SYS_HALF - 1) sys_clk_in <= ~sys_clk_in;
    if (scan_cnt == SCAN_HALF - 1) scan_clk_in <= ~scan_clk_in;
  end
endmodule

/* verification/cfsg_fanout_gate_tb.sv */
// Self-checking bench: drives select and enable, compares every output
// on each checking negedge of a test against a reference of the gating behaviour.
// Assumes the clock source model cfsg_clk_src.
`timescale 1ns/1ns
`define CHK(n, e, s) begin \
  checked++; \
  if ((s) !== (e)) begin \
    errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); \
  end \
end
module cfsg_fanout_gate_tb;
  logic       clock    = 1'h0;
  logic       sys_rst  = 1'h1;
  logic       clk_sel  = 1'h0;
  logic       enable_n = 1'h0;
  logic       sys_clk_in;
  logic       sys_clk_in_n;
  logic       scan_clk_in;
  logic [3:0] q;
  logic [3:0] qn;
  logic       lvl;
  logic       prv;
  logic       gate;
  logic       gnx;
  logic       exp_q;
  int         errors   = 0;
  int         checked  = 0;
  int         cyc      = 0;
  always #25 clock = ~clock;
  cfsg_clk_src u_src (.clock(clock), .sys_clk_in(sys_clk_in), .sys_clk_in_n(sys_clk_in_n), .scan_clk_in(scan_clk_in));
  cfsg_fanout_gate u_dut (.clock(clock), .sys_rst(sys_rst), .sys_clk_in(sys_clk_in), .sys_clk_in_n(sys_clk_in_n),
    .scan_clk_in(scan_clk_in), .clk_sel(clk_sel), .enable_n(enable_n), .fanout_clock_outputs(q),
    .fanout_clock_outputs_n(qn));
  // Reference lags the inputs by one cycle, as the outputs are registered
  always_comb lvl = (clk_sel === 1'h1) ? scan_clk_in : (sys_clk_in & ~sys_clk_in_n);
  always_comb gnx = (prv & ~lvl) ? ~enable_n : gate;
  always @(posedge clock) begin
    prv <= sys_rst ? 1'h0 : lvl;
    gate <= sys_rst ? 1'h0 : gnx;
    exp_q <= sys_rst ? 1'h0 : (lvl & gnx);
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run(input logic sel, input logic en_n);
    @(negedge clock);
    clk_sel = sel;
    enable_n = en_n;
  endtask
  task automatic t_reset();
    // Outputs must already sit parked before reset is let go
    @(negedge clock);
    `CHK("q rst", 4'h0, q)
    `CHK("qn rst", 4'hF, qn)
  endtask
  task automatic t_system();
    run(1'h0, 1'h0);
    repeat (40) begin
      @(negedge clock);
      `CHK("q sys", {4{exp_q}}, q)
      `CHK("qn sys", ~{4{exp_q}}, qn)
    end
  endtask
  task automatic t_scan();
    run(1'h1, 1'h0);
    repeat (40) begin
      @(negedge clock);
      `CHK("q scan", {4{exp_q}}, q)
      `CHK("qn scan", ~{4{exp_q}}, qn)
    end
  endtask
  task automatic t_open();
    run(1'hZ, 1'h0);
    repeat (40) begin
      @(negedge clock);
      `CHK("q open", {4{exp_q}}, q)
      `CHK("qn open", ~{4{exp_q}}, qn)
    end
  endtask
  task automatic t_disable();
    run(1'h0, 1'h1);
    repeat (40) begin
      @(negedge clock);
      `CHK("q off", {4{exp_q}}, q)
      `CHK("qn off", ~{4{exp_q}}, qn)
    end
  endtask
  task automatic t_toggle();
    // Enable flips every other cycle, often mid high phase, where a careless gate would cut a pulse
    repeat (12) begin
      run(1'h0, ~enable_n);
      @(negedge clock);
      `CHK("q tog", {4{exp_q}}, q)
      `CHK("qn tog", ~{4{exp_q}}, qn)
    end
  endtask
  initial begin
    repeat (3) @(negedge clock);
    t_reset();
    sys_rst = 1'h0;
    t_system();
    t_scan();
    t_open();
    t_disable();
    t_toggle();
    t_system();
    test_done();
  end
endmodule
